// ### design/lockprot_pkg.sv
// constants and types shared by the sector protection block
package lockprot_pkg;
   // command codes and addresses
   localparam logic [15:0] CMD_LOCK_SETUP = 16'h0060;
   localparam logic [15:0] CMD_LOAD_SLA = 16'h0061;
   localparam logic [15:0] CMD_SSR_ENTRY = 16'h0088;
   localparam logic [15:0] CMD_RESET = 16'h00f0;
   localparam logic [15:0] CMD_PROG_SETUP = 16'h0025;
   localparam logic [11:0] ADDR_UNLOCK1 = 12'haaa;
   localparam logic [11:0] ADDR_UNLOCK1_W = 12'h555;
   localparam int LOCK_SEL_BIT = 6;
   localparam int SEC_BITS = 8;
   localparam int SMALL_SEC_GROUP = 0;
   localparam logic [7:0] SSR_LAST = 8'hff;
   localparam logic [7:0] SSR_FIRST = 8'h00;
   // lock word fields
   localparam int LW_CUST_BIT = 0;
   localparam int LW_FACT_BIT = 1;
   localparam logic [15:0] LW_RESET = 16'hfffd;
   // apb register offsets
   localparam logic [7:0] REG_CMD_ADDR = 8'h00;
   localparam logic [7:0] REG_CMD_DATA = 8'h04;
   localparam logic [7:0] REG_OP_REQ = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_RANGE = 8'h10;
   localparam logic [7:0] REG_LOCKWORD = 8'h14;
   localparam logic [7:0] REG_UNLOCKED = 8'h18;
   localparam logic [7:0] REG_SSR_BURST = 8'h1c;
   // status bit positions
   localparam int ST_RANGE_DONE = 0;
   localparam int ST_RANGE_DIS = 1;
   localparam int ST_SSR_ACTIVE = 2;
   localparam int ST_OP_OK = 3;
   localparam int ST_OP_PROT = 4;
   localparam int ST_INHIBIT = 5;
   localparam int ST_LOCKOUT = 6;
   // op request codes (written to REG_OP_REQ bits 1:0)
   localparam logic [1:0] OP_PROGRAM = 2'h1;
   localparam logic [1:0] OP_ERASE = 2'h2;
   localparam logic [1:0] OP_CFG = 2'h3;
   // command sequencer states, gray along the lock path
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_C1 = 3'b001,
      ST_C2 = 3'b011,
      ST_C3 = 3'b010,
      ST_SSR = 3'b110
   } seq_t;
endpackage

// ### design/range_check.sv
// combinational test of a sector against the locked range
`timescale 1ns/100ps
module range_check
   import lockprot_pkg::*;
(
   range_if.check rng
);
   // the four small sectors share large-sector slot zero, so one compare covers the group
   assign rng.hit = rng.valid && (rng.query >= rng.lower) && (rng.query <= rng.upper);
endmodule

// ### design/range_if.sv
// range protection state carried between the sequencer and the sector checker
`timescale 1ns/100ps
interface range_if #(parameter int SB = 8);
   logic valid;
   logic [SB-1:0] lower;
   logic [SB-1:0] upper;
   logic [SB-1:0] query;
   logic hit;
   modport owner (output valid, output lower, output upper, output query, input hit);
   modport check (input valid, input lower, input upper, input query, output hit);
endinterface

// ### design/range_lock.sv
// sector range lock, dynamic unlock and secure region control behind apb
// Functional notes
// - valid range lock protects sectors until reset; others need single-sector unlock.
// - lower, upper and all sectors between are locked inclusively.
// - addresses use large-sector granularity; small sectors lock as one group.
// - select address bit must be zero on both address cycles.
// - lower above upper makes the whole sequence invalid.
// - select bit one on either address cycle disables later range locks.
// - only one valid range lock accepted per reset; later ones ignored.
// - unlock aimed inside the locked range leaves the sector locked.
// - previously unlocked sector inside a new range becomes locked.
// - lockout input low refuses program and erase but allows config writes.
// - chip enable and reset low with output enable high at power-up blocks writes; config writes outside secure mode are still granted.
// - lock word bit 0 customer flag, bit 1 factory flag, others read one.
// - customer flag zero blocks secure region programming; one permits it.
// - factory flag reads zero always; customer flag starts at one.
// - each secure word programs once; after lock program fails as protected.
// - entry sector address selects overlaid sector; other sectors read array.
// - secure region bursts wrap from last to first address.
// - secure access denied during embedded op, suspend or other address space.
// - one-cycle entry from idle holds secure access until exit or reset.
// - in secure mode only secure reads, customer program, array reads, exit.
// - all sectors start unlocked after power-up.
`timescale 1ns/100ps
module range_lock
   import lockprot_pkg::*;
#(
   parameter int SB = SEC_BITS
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // device pins, asynchronous
   input wire logic accel_lockout_input,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic reset_pin_n,
   input wire logic power_up,
   // device activity from the array controller
   input wire logic embedded_busy,
   input wire logic suspended,
   input wire logic alternate_address_space,
   // result of protection checks
   output logic op_grant,
   output logic ssr_active,
   output logic [SB-1:0] overlay_sector
);
   typedef struct packed {
      seq_t seq;
      logic [SB-1:0] lower;
      logic [SB-1:0] upper;
      logic range_valid;
      logic range_dis;
      logic [SB-1:0] unlocked_sec;
      logic all_locked;
      logic inhibit;
      logic otp_secure_region;
      logic [SB-1:0] ovl;
      logic [15:0] lockword;
      logic [255:0] ssr_prog;
      logic [7:0] burst;
      logic op_ok;
      logic op_prot;
      logic grant;
      logic [31:0] rdata;
      logic ready;
      logic [15:0] cmd_addr;
      logic lo_sel;
      logic [1:0] acc_s;
      logic [1:0] ce_s;
      logic [1:0] oe_s;
      logic [1:0] rp_s;
      logic [1:0] pu_s;
   } state_t;

   state_t s_q, s_d;
   logic [SB-1:0] query;
   range_if #(.SB(SB)) rng ();

   // sector number from a word address; small sectors fold into slot zero
   function automatic logic [SB-1:0] sec_of(input logic [15:0] a);
      sec_of = a[15:16-SB];
   endfunction

   assign rng.valid = s_q.range_valid;
   assign rng.lower = s_q.lower;
   assign rng.upper = s_q.upper;
   assign rng.query = query;

   range_check u_chk (
      .rng(rng)
   );

   // command writes, protection checks and register access
   always_comb begin
      logic wr;
      logic [15:0] d;
      logic [1:0] op;
      logic sec_locked;
      logic [7:0] woff;
      wr = 1'b0;
      d = 16'h0000;
      op = 2'h0;
      sec_locked = 1'b0;
      woff = 8'h00;
      s_d = s_q;
      query = sec_of(s_q.cmd_addr);
      // pin synchronisers
      s_d.acc_s = {s_q.acc_s[0], accel_lockout_input};
      s_d.ce_s = {s_q.ce_s[0], ce_n};
      s_d.oe_s = {s_q.oe_s[0], oe_n};
      s_d.rp_s = {s_q.rp_s[0], reset_pin_n};
      s_d.pu_s = {s_q.pu_s[0], power_up};
      if (s_q.pu_s[1] && !s_q.ce_s[1] && !s_q.rp_s[1] && s_q.oe_s[1]) begin
         s_d.inhibit = 1'b1;
      end else if (!s_q.pu_s[1]) begin
         s_d.inhibit = 1'b0;
      end
      s_d.ready = psel && !s_q.ready;
      s_d.grant = 1'b0;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            REG_STATUS: s_d.rdata = {25'h0, s_q.acc_s[1], s_q.inhibit, s_q.op_prot,
               s_q.op_ok, s_q.otp_secure_region, s_q.range_dis, s_q.range_valid};
            REG_RANGE: s_d.rdata = {16'h0, 8'(s_q.upper), 8'(s_q.lower)};
            REG_LOCKWORD: s_d.rdata = {16'h0, s_q.lockword};
            REG_UNLOCKED: s_d.rdata = {23'h0, s_q.all_locked, 8'(s_q.unlocked_sec)};
            REG_SSR_BURST: begin
               s_d.rdata = {24'h0, s_q.burst};
               // continuous bursts wrap at the end of the region
               s_d.burst = (s_q.burst == SSR_LAST) ? SSR_FIRST : s_q.burst + 8'h01;
            end
            REG_CMD_ADDR: s_d.rdata = {16'h0, s_q.cmd_addr};
            default: s_d.rdata = 32'h0;
         endcase
      end
      if (psel && penable && s_q.ready && pwrite) begin
         case (paddr)
            REG_CMD_ADDR: s_d.cmd_addr = pwdata[15:0];
            REG_CMD_DATA: begin
               wr = !s_q.inhibit;
               d = pwdata[15:0];
            end
            REG_OP_REQ: op = pwdata[1:0];
            default: ;
         endcase
      end
      // command sequencer
      if (wr) begin
         if (s_q.rp_s[1] == 1'b0) begin
            s_d.seq = ST_IDLE;
         end else begin
            case (s_q.seq)
               ST_IDLE: begin
                  if (d == CMD_LOCK_SETUP && s_q.cmd_addr[11:0] == ADDR_UNLOCK1) begin
                     s_d.seq = ST_C1;
                  end else if (d == CMD_SSR_ENTRY && !embedded_busy && !suspended
                     && !alternate_address_space) begin
                     s_d.seq = ST_SSR;
                     s_d.otp_secure_region = 1'b1;
                     s_d.ovl = sec_of(s_q.cmd_addr);
                     s_d.burst = SSR_FIRST;
                  end else if (d == CMD_LOCK_SETUP) begin
                     // single-step lock or unlock; range members stay locked
                     if (!s_q.cmd_addr[LOCK_SEL_BIT] || rng.hit) begin
                        s_d.all_locked = 1'b1;
                     end else begin
                        s_d.unlocked_sec = sec_of(s_q.cmd_addr);
                        s_d.all_locked = 1'b0;
                     end
                  end
               end
               ST_C1: s_d.seq = (d == CMD_LOCK_SETUP) ? ST_C2 : ST_IDLE;
               ST_C2: begin
                  s_d.seq = ST_IDLE;
                  if (d == CMD_LOAD_SLA) begin
                     s_d.seq = ST_C3;
                     // a refused retry must not move the bound of a live range
                     if (!s_q.range_valid) begin
                        s_d.lower = sec_of(s_q.cmd_addr);
                     end
                     // select bit kept apart so the status flags stay untouched
                     s_d.lo_sel = s_q.cmd_addr[LOCK_SEL_BIT];
                  end
               end
               ST_C3: begin
                  s_d.seq = ST_IDLE;
                  if (d == CMD_LOAD_SLA && !s_q.range_valid && !s_q.range_dis) begin
                     if (s_q.lo_sel || s_q.cmd_addr[LOCK_SEL_BIT]) begin
                        s_d.range_dis = 1'b1;
                     end else if (s_q.lower <= sec_of(s_q.cmd_addr)) begin
                        s_d.upper = sec_of(s_q.cmd_addr);
                        s_d.range_valid = 1'b1;
                     end else begin
                        s_d.lower = s_q.lower;
                     end
                  end
               end
               ST_SSR: begin
                  // only exit or the reset pin leaves the secure map; other data words are ignored
                  if (d == CMD_RESET) begin
                     s_d.seq = ST_IDLE;
                     s_d.otp_secure_region = 1'b0;
                  end
               end
               default: s_d.seq = ST_IDLE;
            endcase
         end
      end
      // program, erase and config requests checked against protection
      if (op != 2'h0) begin
         s_d.op_ok = 1'b0;
         s_d.op_prot = 1'b0;
         // configuration writes are not part of the secure command set
         if (op == OP_CFG && !s_q.otp_secure_region) begin
            s_d.op_ok = 1'b1;
            s_d.grant = 1'b1;
         end else if (!s_q.acc_s[1] || s_q.inhibit) begin
            s_d.op_prot = 1'b1;
         end else if (s_q.otp_secure_region) begin
            woff = s_q.cmd_addr[7:0];
            if (op == OP_PROGRAM && s_q.lockword[LW_CUST_BIT] && !s_q.ssr_prog[woff]) begin
               s_d.ssr_prog[woff] = 1'b1;
               s_d.op_ok = 1'b1;
               s_d.grant = 1'b1;
            end else begin
               s_d.op_prot = 1'b1;
            end
         end else begin
            sec_locked = rng.hit || s_q.all_locked ||
               (s_q.unlocked_sec != sec_of(s_q.cmd_addr) && s_q.unlocked_sec != '1);
            if (sec_locked) begin
               s_d.op_prot = 1'b1;
            end else begin
               s_d.op_ok = 1'b1;
               s_d.grant = 1'b1;
            end
         end
      end
      // customer flag is cleared by writing zero to the lock word in secure mode
      if (psel && penable && s_q.ready && pwrite && paddr == REG_LOCKWORD && s_q.otp_secure_region
          && s_q.acc_s[1] && !s_q.inhibit && !pwdata[LW_CUST_BIT]) begin
         s_d.lockword[LW_CUST_BIT] = 1'b0;
      end
      s_d.lockword[LW_FACT_BIT] = 1'b0;
      if (s_q.rp_s[1] == 1'b0) begin
         s_d.range_valid = 1'b0;
         s_d.range_dis = 1'b0;
         s_d.otp_secure_region = 1'b0;
         s_d.all_locked = 1'b0;
         s_d.unlocked_sec = '1;
      end
   end

   // state register; the lock word's customer flag survives only in otp terms
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= '0;
         s_q.seq <= ST_IDLE;
         s_q.lockword <= LW_RESET;
         s_q.unlocked_sec <= '1;
         s_q.rp_s <= 2'b11;
         // idle level of the lockout pin, so no false lockout follows reset
         s_q.acc_s <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = 1'b0;
   assign op_grant = s_q.grant;
   assign ssr_active = s_q.otp_secure_region;
   assign overlay_sector = s_q.ovl;
endmodule

// ### verification/flash_host.sv
// host controller model issuing command and register cycles over apb
`timescale 1ns/100ps
module flash_host (
   // clock
   input wire logic clk_sys,
   // apb master side
   output logic psel = 0,
   output logic penable = 0,
   output logic pwrite = 0,
   output logic [7:0] paddr = 8'h00,
   output logic [31:0] pwdata = 32'h00000000,
   input wire logic [31:0] prdata,
   input wire logic pready
);
   // one transfer; request held until ready is seen, then data turned over
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // released data does not keep its last value
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h00000000, q);
   endtask
endmodule

// ### verification/range_lock_chk.sv
// concurrent checks on the ports of the sector protection block
`timescale 1ns/100ps
module range_lock_chk
   import lockprot_pkg::*;
#(
   parameter int SB = SEC_BITS
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // pins and activity
   input wire logic reset_pin_n,
   input wire logic embedded_busy,
   input wire logic suspended,
   input wire logic alternate_address_space,
   // results
   input wire logic op_grant,
   input wire logic ssr_active,
   input wire logic [SB-1:0] overlay_sector
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // checks on the bus answer and on the protection outputs
   AST_RST_OUT: assert property (disable iff (1'b0) rst |=> !ssr_active && !op_grant)
      else $error("outputs not cleared by reset");
   AST_SLVERR: assert property (pslverr == 1'b0)
      else $error("slave error raised");
   AST_READY_WAIT: assert property (psel && penable && !$past(penable) |-> pready)
      else $error("ready missing in first access cycle");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   AST_GRANT_CAUSE: assert property (op_grant |->
      $past(psel && penable && pready && pwrite && paddr == REG_OP_REQ))
      else $error("grant without an op request");
   AST_GRANT_PULSE: assert property (op_grant |=> !op_grant)
      else $error("grant is not a pulse");
   AST_ENTRY_FREE: assert property ($rose(ssr_active) |->
      $past(!embedded_busy && !suspended && !alternate_address_space))
      else $error("secure entry while device busy");
   AST_ENTRY_WRITE: assert property ($rose(ssr_active) |->
      $past(psel && penable && pready && pwrite))
      else $error("secure entry without a write");
   AST_EXIT_CAUSE: assert property ($fell(ssr_active) |->
      $past(pwrite && pready) || !$past(reset_pin_n, 2) || !$past(reset_pin_n, 3)
      || !$past(reset_pin_n, 4))
      else $error("secure mode left without exit or reset");
   AST_OVERLAY_HOLD: assert property (ssr_active && $past(ssr_active) |-> $stable(overlay_sector))
      else $error("overlay sector moved in secure mode");
   // main scenarios reached
   cover property ($rose(ssr_active));
   cover property ($fell(ssr_active));
   cover property (op_grant);
endmodule

bind range_lock range_lock_chk #(.SB(SB)) i_range_lock_chk (.clk_sys(clk_sys), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .reset_pin_n(reset_pin_n), .embedded_busy(embedded_busy),
   .suspended(suspended), .alternate_address_space(alternate_address_space),
   .op_grant(op_grant), .ssr_active(ssr_active), .overlay_sector(overlay_sector));

// ### verification/range_lock_tb_top.sv
// self-checking bench for the sector range lock block
`timescale 1ns/100ps
module range_lock_tb_top;
   import lockprot_pkg::*;
   logic clk_sys = 0, rst = 1, accel_lockout_input = 1, ce_n = 1, oe_n = 1, reset_pin_n = 1;
   logic power_up = 0, embedded_busy = 0, suspended = 0, alternate_address_space = 0;
   logic psel, penable, pwrite, pready, pslverr, op_grant, ssr_active;
   logic [7:0] paddr, overlay_sector;
   logic [31:0] pwdata, prdata, rd;
   int failures = 0, n_compared = 0, i;
   range_lock #(.SB(8)) i_range_lock (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .accel_lockout_input, .ce_n, .oe_n, .reset_pin_n, .power_up,
      .embedded_busy, .suspended, .alternate_address_space, .op_grant, .ssr_active,
      .overlay_sector);
   flash_host i_flash_host (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
   // 25 MHz system clock
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   task results;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cmd(input logic [15:0] a, input logic [15:0] d);
      i_flash_host.wr(REG_CMD_ADDR, {16'h0000, a});
      i_flash_host.wr(REG_CMD_DATA, {16'h0000, d});
   endtask
   // four-cycle range lock; s_lo and s_hi drive the select address bit
   task rlock(input logic [7:0] lo, input logic [7:0] hi, input logic s_lo, input logic s_hi);
      cmd(16'h0aaa, CMD_LOCK_SETUP);
      cmd(16'h02aa, CMD_LOCK_SETUP);
      cmd({lo, 1'b0, s_lo, 6'h00}, CMD_LOAD_SLA);
      cmd({hi, 1'b0, s_hi, 6'h00}, CMD_LOAD_SLA);
   endtask
   task unlock(input logic [7:0] sec);
      cmd(16'h0555, CMD_LOCK_SETUP);
      cmd(16'h02aa, CMD_LOCK_SETUP);
      cmd({sec, 8'h40}, CMD_LOCK_SETUP);
   endtask
   // request an operation on a sector and compare the ok and protected flags
   task op(input logic [7:0] sec, input logic [1:0] code, input logic ok);
      i_flash_host.wr(REG_CMD_ADDR, {16'h0000, sec, 8'h00});
      i_flash_host.wr(REG_OP_REQ, {30'h0, code});
      i_flash_host.rd(REG_STATUS, rd);
      chk({30'h0, rd[ST_OP_PROT], rd[ST_OP_OK]}, {30'h0, !ok, ok});
   endtask
   task stat(input int b, input logic v);
      i_flash_host.rd(REG_STATUS, rd);
      chk({31'h0, rd[b]}, {31'h0, v});
   endtask
   task pin_reset;
      reset_pin_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      reset_pin_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask
   // watchdog, far above the expected run time
   initial begin
      #(40 * 40000);
      failures++;
      results;
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      i_flash_host.rd(REG_LOCKWORD, rd);
      chk(rd, {16'h0000, LW_RESET});
      op(8'h05, OP_PROGRAM, 1'b1);
      rlock(8'h03, 8'h02, 1'b0, 1'b0);
      stat(ST_RANGE_DONE, 1'b0);
      unlock(8'h03);
      op(8'h03, OP_PROGRAM, 1'b1);
      rlock(8'h02, 8'h04, 1'b0, 1'b0);
      i_flash_host.rd(REG_RANGE, rd);
      chk(rd, 32'h00000402);
      for (i = 1; i < 6; i++) op(i[7:0], OP_ERASE, 1'b0);
      unlock(8'h03);
      op(8'h03, OP_PROGRAM, 1'b0);
      unlock(8'h06);
      op(8'h06, OP_PROGRAM, 1'b1);
      rlock(8'h00, 8'h07, 1'b0, 1'b0);
      i_flash_host.rd(REG_RANGE, rd);
      chk(rd, 32'h00000402);
      op(8'h06, OP_ERASE, 1'b1);
      // lockout pin refuses array ops but not configuration
      accel_lockout_input <= 1'b0;
      repeat (4) @(posedge clk_sys);
      op(8'h06, OP_PROGRAM, 1'b0);
      op(8'h06, OP_CFG, 1'b1);
      accel_lockout_input <= 1'b1;
      pin_reset;
      op(8'h09, OP_PROGRAM, 1'b1);
      rlock(8'h01, 8'h02, 1'b1, 1'b0);
      stat(ST_RANGE_DIS, 1'b1);
      rlock(8'h05, 8'h05, 1'b0, 1'b0);
      stat(ST_RANGE_DONE, 1'b0);
      pin_reset;
      rlock(8'h05, 8'h05, 1'b0, 1'b0);
      op(8'h05, OP_PROGRAM, 1'b0);
      unlock(8'h04);
      op(8'h04, OP_PROGRAM, 1'b1);
      // secure entry refused while busy, suspended or another space is open
      for (i = 0; i < 3; i++) begin
         {embedded_busy, suspended, alternate_address_space} <= 3'b001 << i;
         cmd(16'h0555, CMD_SSR_ENTRY);
         @(posedge clk_sys);
         chk({31'h0, ssr_active}, 32'h0);
      end
      {embedded_busy, suspended, alternate_address_space} <= 3'b000;
      cmd(16'h0555, CMD_SSR_ENTRY);
      repeat (2) @(posedge clk_sys);
      chk({23'h0, ssr_active, overlay_sector}, 32'h00000105);
      cmd(16'h0555, CMD_LOCK_SETUP);
      stat(ST_SSR_ACTIVE, 1'b1);
      for (i = 0; i < 257; i++) begin
         i_flash_host.rd(REG_SSR_BURST, rd);
         chk({24'h0, rd[7:0]}, {24'h0, i[7:0]});
      end
      op(8'h05, OP_PROGRAM, 1'b1);
      op(8'h05, OP_PROGRAM, 1'b0);
      op(8'h05, OP_CFG, 1'b0);
      i_flash_host.wr(REG_LOCKWORD, 32'h0000fffe);
      i_flash_host.wr(REG_LOCKWORD, 32'h0000ffff);
      i_flash_host.rd(REG_LOCKWORD, rd);
      chk(rd, 32'h0000fffc);
      op(8'h05, OP_PROGRAM, 1'b0);
      cmd(16'h0000, CMD_RESET);
      stat(ST_SSR_ACTIVE, 1'b0);
      // power-up write inhibit
      power_up <= 1'b1;
      ce_n <= 1'b0;
      reset_pin_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      stat(ST_INHIBIT, 1'b1);
      // pin reset released, so only the latched inhibit can refuse the entry
      reset_pin_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      cmd(16'h0555, CMD_SSR_ENTRY);
      @(posedge clk_sys);
      chk({31'h0, ssr_active}, 32'h0);
      power_up <= 1'b0;
      repeat (4) @(posedge clk_sys);
      stat(ST_INHIBIT, 1'b0);
      results;
   end
endmodule
